// File: src/cpu_ops_defs.vh
`ifndef CPU_OPS_DEFS_VH
`define CPU_OPS_DEFS_VH

`define INSTR_W 14
`define PC_W 15
`define PC_RESET 15'h0000
`define W_RESET 8'h00
`define ZERO_RESET 1'b0
`define PC_STEP 15'h0001
`define PC_SKIP_STEP 15'h0002

// Opcode matching
`define OP_CALL_WORKING 14'h000A
`define OPMASK_FILE 14'h3F00
`define OP_COMPLEMENT 14'h0900
`define OP_DECREMENT 14'h0300
`define OP_DECREMENT_SKIP 14'h0B00
`define OPMASK_CLR 14'h3F80
`define OP_CLEAR_FILE 14'h0180
`define OP_CLEAR_WORKING 14'h0100
`define OPMASK_BRANCH 14'h3800
`define OP_BRANCH 14'h2800

// Field positions
`define DEST_BIT 7
`define FADDR_HI 6
`define FADDR_LO 0
`define BIMM_HI 10
`define BIMM_LO 0

`endif

// File: src/file_reg_ram.v
`timescale 1ns/1ps
module file_reg_ram (
    mclk,
    rd_addr,
    rd_data,
    wr_en,
    wr_addr,
    wr_data
);
    input wire mclk;
    input wire [6:0] rd_addr;
    output wire [7:0] rd_data;
    input wire wr_en;
    input wire [6:0] wr_addr;
    input wire [7:0] wr_data;

    // Contents are undefined after reset, as in the real data memory
    reg [7:0] mem [0:127];

    assign rd_data = mem[rd_addr];

    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// File: src/cpu_branch_clear_decrement_ops.v
`timescale 1ns/1ps
`include "cpu_ops_defs.vh"
module cpu_branch_clear_decrement_ops (
    mclk,
    reset_n,
    instr_word,
    instr_valid,
    upper_pc_latch,
    preload_en,
    preload_addr,
    preload_data,
    pc_reg,
    working_reg,
    zero_flag_reg,
    return_stack_top_reg,
    stack_push_reg,
    nop_cycle_reg,
    file_wr_strobe_reg,
    file_wr_addr_reg,
    file_wr_data_reg
);
    input wire mclk;
    input wire reset_n;
    input wire [13:0] instr_word;
    input wire instr_valid;
    input wire [6:0] upper_pc_latch;
    input wire preload_en;
    input wire [6:0] preload_addr;
    input wire [7:0] preload_data;
    output reg [14:0] pc_reg;
    output reg [7:0] working_reg;
    output reg zero_flag_reg;
    output reg [14:0] return_stack_top_reg;
    output reg stack_push_reg;
    output reg nop_cycle_reg;
    output reg file_wr_strobe_reg;
    output reg [6:0] file_wr_addr_reg;
    output reg [7:0] file_wr_data_reg;

    function match;
        input [13:0] word;
        input [13:0] mask;
        input [13:0] code;
        begin
            match = ((word & mask) == code);
        end
    endfunction

    function is_zero;
        input [7:0] value;
        begin
            is_zero = (value == 8'h00);
        end
    endfunction

    wire [6:0] faddr;
    wire [10:0] branch_imm;
    wire dest_file;
    wire [7:0] file_rd_data;
    wire [7:0] comp_value;
    wire [7:0] dec_value;
    wire [14:0] pc_plus_one;
    wire [14:0] pc_plus_two;
    wire execute;

    assign faddr = instr_word[`FADDR_HI:`FADDR_LO];
    assign branch_imm = instr_word[`BIMM_HI:`BIMM_LO];
    assign dest_file = instr_word[`DEST_BIT];
    assign comp_value = ~file_rd_data;
    assign dec_value = file_rd_data - 8'h01;
    assign pc_plus_one = pc_reg + `PC_STEP;
    assign pc_plus_two = pc_reg + `PC_SKIP_STEP;
    // A discarded slot consumes its cycle whether or not a word is offered
    assign execute = instr_valid & ~nop_cycle_reg;

    // One decode line per operation; the masks keep them mutually exclusive
    wire op_call;
    wire op_branch;
    wire op_complement;
    wire op_clear_file;
    wire op_clear_working;
    wire op_decrement;
    wire op_decrement_skip;
    wire skip_taken;

    assign op_call = (instr_word == `OP_CALL_WORKING);
    assign op_branch = match(instr_word, `OPMASK_BRANCH, `OP_BRANCH);
    assign op_complement = match(instr_word, `OPMASK_FILE, `OP_COMPLEMENT);
    assign op_clear_file = match(instr_word, `OPMASK_CLR, `OP_CLEAR_FILE);
    assign op_clear_working = match(instr_word, `OPMASK_CLR, `OP_CLEAR_WORKING);
    assign op_decrement = match(instr_word, `OPMASK_FILE, `OP_DECREMENT);
    assign op_decrement_skip = match(instr_word, `OPMASK_FILE, `OP_DECREMENT_SKIP);
    assign skip_taken = op_decrement_skip & is_zero(dec_value);

    reg core_wr_en;
    reg [7:0] core_wr_data;
    reg [14:0] pc_next;
    reg [7:0] working_next;
    reg zero_flag_next;
    reg [14:0] return_stack_top_next;
    reg stack_push_next;
    reg nop_cycle_next;

    // Preload shares the write port; the core wins if both strike at once
    wire ram_wr_en;
    wire [6:0] ram_wr_addr;
    wire [7:0] ram_wr_data;

    assign ram_wr_en = core_wr_en | preload_en;
    assign ram_wr_addr = core_wr_en ? faddr : preload_addr;
    assign ram_wr_data = core_wr_en ? core_wr_data : preload_data;

    file_reg_ram u_file_reg_ram (
        .mclk(mclk),
        .rd_addr(faddr),
        .rd_data(file_rd_data),
        .wr_en(ram_wr_en),
        .wr_addr(ram_wr_addr),
        .wr_data(ram_wr_data)
    );

    always @* begin
        core_wr_en = 1'b0;
        core_wr_data = 8'h00;
        pc_next = pc_reg;
        working_next = working_reg;
        zero_flag_next = zero_flag_reg;
        return_stack_top_next = return_stack_top_reg;
        stack_push_next = 1'b0;
        nop_cycle_next = 1'b0;
        if (execute) begin
            // Words outside this group act as single-cycle no-ops here
            pc_next = pc_plus_one;
            if (op_call) begin
                // Only the top entry is kept; deeper levels sit outside this block
                return_stack_top_next = pc_plus_one;
                stack_push_next = 1'b1;
                pc_next = {upper_pc_latch, working_reg};
                nop_cycle_next = 1'b1;
            end else if (op_branch) begin
                pc_next = {upper_pc_latch[6:3], branch_imm};
                nop_cycle_next = 1'b1;
            end else if (op_complement) begin
                zero_flag_next = is_zero(comp_value);
                if (dest_file) begin
                    core_wr_en = 1'b1;
                    core_wr_data = comp_value;
                end else begin
                    working_next = comp_value;
                end
            end else if (op_clear_file) begin
                core_wr_en = 1'b1;
                core_wr_data = 8'h00;
                zero_flag_next = 1'b1;
            end else if (op_clear_working) begin
                working_next = 8'h00;
                zero_flag_next = 1'b1;
            end else if (op_decrement) begin
                zero_flag_next = is_zero(dec_value);
                if (dest_file) begin
                    core_wr_en = 1'b1;
                    core_wr_data = dec_value;
                end else begin
                    working_next = dec_value;
                end
            end else if (op_decrement_skip) begin
                // Zero flag left alone on purpose
                if (dest_file) begin
                    core_wr_en = 1'b1;
                    core_wr_data = dec_value;
                end else begin
                    working_next = dec_value;
                end
                if (skip_taken) begin
                    // Step over the prefetched word now, then idle one cycle
                    pc_next = pc_plus_two;
                    nop_cycle_next = 1'b1;
                end
            end
        end
    end

    // Program flow: counter, stack top and the one-cycle pulses
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pc_reg <= `PC_RESET;
            return_stack_top_reg <= `PC_RESET;
            stack_push_reg <= 1'b0;
            nop_cycle_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            return_stack_top_reg <= return_stack_top_next;
            stack_push_reg <= stack_push_next;
            nop_cycle_reg <= nop_cycle_next;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            working_reg <= `W_RESET;
        end else begin
            working_reg <= working_next;
        end
    end

    // Kept apart so flag-neutral paths cannot disturb it by accident
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            zero_flag_reg <= `ZERO_RESET;
        end else begin
            zero_flag_reg <= zero_flag_next;
        end
    end

    // Mirrors the shared write port, so preload writes show here as well
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            file_wr_strobe_reg <= 1'b0;
            file_wr_addr_reg <= 7'h00;
            file_wr_data_reg <= 8'h00;
        end else begin
            file_wr_strobe_reg <= ram_wr_en;
            file_wr_addr_reg <= ram_wr_addr;
            file_wr_data_reg <= ram_wr_data;
        end
    end
endmodule

// File: verif/cpu_ops_asserts.sv
`timescale 1ns/1ps
module cpu_ops_asserts (
    input logic mclk,
    input logic reset_n,
    input logic [13:0] instr_word,
    input logic instr_valid,
    input logic [6:0] upper_pc_latch,
    input logic [14:0] pc_reg,
    input logic [7:0] working_reg,
    input logic zero_flag_reg,
    input logic [14:0] return_stack_top_reg,
    input logic stack_push_reg,
    input logic nop_cycle_reg,
    input logic file_wr_strobe_reg,
    input logic [6:0] file_wr_addr_reg,
    input logic [7:0] file_wr_data_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Offered words during the forced nop are dropped
    wire ex = instr_valid && !nop_cycle_reg;
    wire is_call = ex && instr_word == 14'h000A;
    wire is_br = ex && (instr_word & 14'h3800) == 14'h2800;
    wire is_skip = ex && (instr_word & 14'h3F00) == 14'h0B00;
    wire is_clear_file_reg = ex && (instr_word & 14'h3F80) == 14'h0180;
    sequence s_flush;
        nop_cycle_reg ##1 !nop_cycle_reg;
    endsequence
    property p_call;
        is_call |=> pc_reg == {$past(upper_pc_latch), $past(working_reg)} && stack_push_reg
            && return_stack_top_reg == $past(pc_reg) + 15'h0001 ##0 s_flush;
    endproperty
    a_call: assert property (p_call) else $error("call target or push wrong");
    property p_call_flags;
        is_call |=> $stable(zero_flag_reg);
    endproperty
    a_call_flags: assert property (p_call_flags) else $error("call changed zero flag");
    property p_branch;
        is_br |=> pc_reg == {$past(upper_pc_latch[6:3]), $past(instr_word[10:0])} && !stack_push_reg
            && $stable(return_stack_top_reg) && $stable(zero_flag_reg) ##0 s_flush;
    endproperty
    a_branch: assert property (p_branch) else $error("branch result wrong");
    property p_clear_working_reg;
        ex && (instr_word & 14'h3F80) == 14'h0100 |=> working_reg == 8'h00 && zero_flag_reg;
    endproperty
    a_clear_working_reg: assert property (p_clear_working_reg) else $error("clear working reg wrong");
    property p_clear_file_reg;
        is_clear_file_reg |=> file_wr_strobe_reg && file_wr_data_reg == 8'h00 && zero_flag_reg
            && file_wr_addr_reg == $past(instr_word[6:0]);
    endproperty
    a_clear_file_reg: assert property (p_clear_file_reg) else $error("clear file reg wrong");
    property p_skip_flag;
        is_skip |=> $stable(zero_flag_reg);
    endproperty
    a_skip_flag: assert property (p_skip_flag) else $error("skip changed zero flag");
    property p_skip_pc;
        is_skip |=> (pc_reg == $past(pc_reg) + 15'h0002 && nop_cycle_reg)
            || (pc_reg == $past(pc_reg) + 15'h0001 && !nop_cycle_reg);
    endproperty
    a_skip_pc: assert property (p_skip_pc) else $error("skip pc step wrong");
    property p_nop;
        nop_cycle_reg |=> $stable(pc_reg) && !nop_cycle_reg;
    endproperty
    a_nop: assert property (p_nop) else $error("nop cycle not single");
    property p_complement_file_reg;
        ex && (instr_word & 14'h3F80) == 14'h0980 |=> file_wr_strobe_reg
            && file_wr_addr_reg == $past(instr_word[6:0]);
    endproperty
    a_complement_file_reg: assert property (p_complement_file_reg) else $error("complement file write missing");
endmodule
bind cpu_branch_clear_decrement_ops cpu_ops_asserts cpu_ops_asserts_inst (.*);

// File: verif/cpu_branch_clear_decrement_ops_bench.sv
`timescale 1ns/1ps
module cpu_branch_clear_decrement_ops_bench;
    logic mclk = 0, reset_n = 0, instr_valid = 0, preload_en = 0;
    logic [13:0] instr_word = 0;
    logic [6:0] upper_pc_latch = 0, preload_addr = 0, f;
    logic [7:0] preload_data = 0, w = 0, v;
    wire [14:0] pc_reg, return_stack_top_reg;
    wire [7:0] working_reg, file_wr_data_reg;
    wire [6:0] file_wr_addr_reg;
    wire zero_flag_reg, stack_push_reg, nop_cycle_reg, file_wr_strobe_reg;
    int num_errors = 0, tests_run = 0;
    logic [31:0] seed = 32'h623319CE, r;
    logic [7:0] mem[128];
    logic [14:0] pc = 0, st = 0;
    logic [2:0] k;
    logic z = 0, wr, nop, d;
    logic [13:0] op[8] = '{14'h0900, 14'h0300, 14'h0B00, 14'h0180, 14'h0100, 14'h000A, 14'h2800, 14'h0000};
    cpu_branch_clear_decrement_ops cpu_branch_clear_decrement_ops_inst (.*);
    initial begin
        forever #25 mclk = ~mclk;
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [14:0] e, input logic [14:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h got %h", n, e, g);
        end
    endtask
    task complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge mclk);
        #1 reset_n = 1;
        // Small values so decrements often reach zero
        for (int i = 0; i < 128; i++) begin
            r = xs();
            preload_en = 1;
            preload_addr = i[6:0];
            preload_data = {6'h00, r[1:0]};
            mem[i] = preload_data;
            @(posedge mclk);
            #1;
            chk("preload", {i[6:0], mem[i]}, {file_wr_addr_reg, file_wr_data_reg});
            chk("preload_wr", 15'h0001, {14'h0, file_wr_strobe_reg});
        end
        preload_en = 0;
        $display("test preload done");
        for (int i = 0; i < 600; i++) begin
            r = xs();
            f = r[6:0];
            d = r[7];
            k = r[18:16];
            upper_pc_latch = r[30:24];
            instr_word = op[k] | (k < 3 ? {6'h00, d, f} : k < 5 ? {7'h00, f} : k == 6 ? {3'h0, r[10:0]} : 14'h0);
            v = k == 0 ? ~mem[f] : k < 3 ? mem[f] - 8'h01 : 8'h00;
            wr = k < 3 ? d : k == 3;
            nop = (k == 5 || k == 6 || (k == 2 && v == 8'h00));
            if (k < 5 && k != 2)
                z = k > 2 || v == 8'h00;
            if (k == 5)
                st = pc + 15'h0001;
            pc = k == 5 ? {upper_pc_latch, w} : k == 6 ? {upper_pc_latch[6:3], r[10:0]} : pc + (nop ? 2 : 1);
            if (wr)
                mem[f] = v;
            else if (k < 5)
                w = v;
            instr_valid = 1;
            @(posedge mclk);
            #1;
            chk("pc", pc, pc_reg);
            chk("working", {7'h00, w}, {7'h00, working_reg});
            chk("zero", {14'h0, z}, {14'h0, zero_flag_reg});
            chk("push", {14'h0, k == 5}, {14'h0, stack_push_reg});
            chk("nop", {14'h0, nop}, {14'h0, nop_cycle_reg});
            chk("file_wr", {14'h0, wr}, {14'h0, file_wr_strobe_reg});
            if (wr)
                chk("file_data", {f, v}, {file_wr_addr_reg, file_wr_data_reg});
            if (k == 5)
                chk("stack_top", st, return_stack_top_reg);
            if (nop) begin
                r = xs();
                instr_word = r[13:0];
                instr_valid = r[20];
                @(posedge mclk);
                #1;
                chk("pc_flush", pc, pc_reg);
                chk("nop_end", 15'h0, {14'h0, nop_cycle_reg});
            end
        end
        $display("test random_ops done");
        complete_run();
    end
endmodule
